// File: verilog/tlip_ctrl.sv
`timescale 1ns/1ps
`include "tlip_params.svh"
// Contract
// - priority regs at B8H and A9H
// - reset loads 00H and A0H
// - bit 7 writes ignored
// - priority bits for seven primary sources
// - priority bits interval, supply, serial
// - enables interval, supply, serial at 2..0
// - high level pre-empts low routine
// - high level wins simultaneous arrival
// - same level cannot pre-empt
// - fixed polling order within level
// - push pc then load vector
// - vectors external, timers, uart
// - vectors timer2, adc, serial, supply, interval, watchdog
// - global enable gates all requests
// - primary enables at bits 6..0
module tlip_ctrl
  import tlip_pkg::*;
#(
  parameter int NSRC = `TLIP_NSRC
)(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic [7:0]  sfr_addr,
  input  wire logic [7:0]  sfr_wdata,
  input  wire logic        sfr_wr,
  input  wire logic        sfr_bit_wr,
  input  wire logic [2:0]  sfr_bit_sel,
  input  wire logic        sfr_bit_val,
  input  wire logic        sfr_rd,
  output logic      [7:0]  sfr_rdata,
  output logic             sfr_hit,
  input  wire logic        supply_monitor_request,
  input  wire logic        watchdog_request,
  input  wire logic        ext0_request,
  input  wire logic        ext1_request,
  input  wire logic        adc_primary_done,
  input  wire logic        adc_auxiliary_done,
  input  wire logic        timer0_overflow,
  input  wire logic        timer1_overflow,
  input  wire logic        timer2_overflow,
  input  wire logic        timer2_external_flag,
  input  wire logic        spi_request,
  input  wire logic        twowire_request,
  input  wire logic        uart_receive_flag,
  input  wire logic        uart_send_flag,
  input  wire logic        interval_counter_request,
  input  wire logic        insn_boundary,
  input  wire logic        reti_done,
  output logic             push_pc,
  output logic             load_pc,
  output logic      [15:0] vector_addr,
  output logic      [3:0]  ack_src,
  output logic      [1:0]  in_service
);
  // the source map below is fixed, so no other count can be served
  if (NSRC != `TLIP_NSRC)
  begin : g_bad_nsrc
    $error("tlip_ctrl: NSRC must equal source count");
  end

  logic [7:0]      enable_reg_r;
  logic [7:0]      priority_select_reg_r;
  logic [7:0]      secondary_enable_priority_reg_r;
  logic [NSRC-1:0] flag;
  logic [NSRC-1:0] en;
  logic [NSRC-1:0] lvl;
  logic [NSRC-1:0] elig;
  logic [NSRC-1:0] req_hi;
  logic [NSRC-1:0] req_lo;
  logic            hit_hi;
  logic            hit_lo;
  logic [3:0]      idx_hi;
  logic [3:0]      idx_lo;
  logic            take;
  logic            take_hi;
  logic [3:0]      take_idx;
  tlip_state_t     state_r;
  logic [3:0]      pend_idx_r;
  logic            pend_hi_r;
  logic [1:0]      in_service_r;

  // vector lookup by source index
  function automatic logic [15:0] vec_of(input logic [3:0] s);
    case (tlip_src_t'(s))
      TLIP_SRC_SUPPLY:   vec_of = `TLIP_VEC_SUPPLY;
      TLIP_SRC_WATCHDOG: vec_of = `TLIP_VEC_WATCHDOG;
      TLIP_SRC_EXT0:     vec_of = `TLIP_VEC_EXT0;
      TLIP_SRC_ADC:      vec_of = `TLIP_VEC_ADC;
      TLIP_SRC_TIMER0:   vec_of = `TLIP_VEC_TIMER0;
      TLIP_SRC_EXT1:     vec_of = `TLIP_VEC_EXT1;
      TLIP_SRC_TIMER1:   vec_of = `TLIP_VEC_TIMER1;
      TLIP_SRC_SERIAL:   vec_of = `TLIP_VEC_SERIAL;
      TLIP_SRC_UART:     vec_of = `TLIP_VEC_UART;
      TLIP_SRC_TIMER2:   vec_of = `TLIP_VEC_TIMER2;
      default:           vec_of = `TLIP_VEC_INTERVAL;
    endcase
  endfunction : vec_of

  // byte or bit write merge with a write mask
  function automatic logic [7:0] wr_merge(input logic [7:0] old,
                                          input logic [7:0] mask,
                                          input logic       byte_wr,
                                          input logic [7:0] data,
                                          input logic [2:0] sel,
                                          input logic       val);
    logic [7:0] nv;
    nv = old;
    if (byte_wr)
      nv = data;
    else
      nv[sel] = val;
    wr_merge = (nv & mask) | (old & ~mask);
  endfunction : wr_merge

  // source flags, combined where two events share a vector
  assign flag[TLIP_SRC_SUPPLY]   = supply_monitor_request;
  assign flag[TLIP_SRC_WATCHDOG] = watchdog_request;
  assign flag[TLIP_SRC_EXT0]     = ext0_request;
  assign flag[TLIP_SRC_ADC]      = adc_primary_done | adc_auxiliary_done;
  assign flag[TLIP_SRC_TIMER0]   = timer0_overflow;
  assign flag[TLIP_SRC_EXT1]     = ext1_request;
  assign flag[TLIP_SRC_TIMER1]   = timer1_overflow;
  assign flag[TLIP_SRC_SERIAL]   = spi_request | twowire_request;
  assign flag[TLIP_SRC_UART]     = uart_receive_flag | uart_send_flag;
  assign flag[TLIP_SRC_TIMER2]   = timer2_overflow | timer2_external_flag;
  assign flag[TLIP_SRC_INTERVAL] = interval_counter_request;

  // individual enables; the watchdog has no enable bit of its own and is gated by the global enable only
  assign en[TLIP_SRC_SUPPLY]   = secondary_enable_priority_reg_r[1];
  assign en[TLIP_SRC_WATCHDOG] = 1'b1;
  assign en[TLIP_SRC_EXT0]     = enable_reg_r[0];
  assign en[TLIP_SRC_ADC]      = enable_reg_r[6];
  assign en[TLIP_SRC_TIMER0]   = enable_reg_r[1];
  assign en[TLIP_SRC_EXT1]     = enable_reg_r[2];
  assign en[TLIP_SRC_TIMER1]   = enable_reg_r[3];
  assign en[TLIP_SRC_SERIAL]   = secondary_enable_priority_reg_r[0];
  assign en[TLIP_SRC_UART]     = enable_reg_r[4];
  assign en[TLIP_SRC_TIMER2]   = enable_reg_r[5];
  assign en[TLIP_SRC_INTERVAL] = secondary_enable_priority_reg_r[2];

  // priority levels; the watchdog sits on the high level
  assign lvl[TLIP_SRC_SUPPLY]   = secondary_enable_priority_reg_r[5];
  assign lvl[TLIP_SRC_WATCHDOG] = 1'b1;
  assign lvl[TLIP_SRC_EXT0]     = priority_select_reg_r[0];
  assign lvl[TLIP_SRC_ADC]      = priority_select_reg_r[6];
  assign lvl[TLIP_SRC_TIMER0]   = priority_select_reg_r[1];
  assign lvl[TLIP_SRC_EXT1]     = priority_select_reg_r[2];
  assign lvl[TLIP_SRC_TIMER1]   = priority_select_reg_r[3];
  assign lvl[TLIP_SRC_SERIAL]   = secondary_enable_priority_reg_r[4];
  assign lvl[TLIP_SRC_UART]     = priority_select_reg_r[4];
  assign lvl[TLIP_SRC_TIMER2]   = priority_select_reg_r[5];
  assign lvl[TLIP_SRC_INTERVAL] = secondary_enable_priority_reg_r[6];

  // eligibility and split by level
  assign elig   = flag & en & {NSRC{enable_reg_r[`TLIP_BIT_GLOBAL]}};
  assign req_hi = elig & lvl;
  assign req_lo = elig & ~lvl;

  tlip_poll #(
    .NSRC (NSRC)
  ) u_poll_hi (
    .req (req_hi),
    .hit (hit_hi),
    .idx (idx_hi)
  );

  tlip_poll #(
    .NSRC (NSRC)
  ) u_poll_lo (
    .req (req_lo),
    .hit (hit_lo),
    .idx (idx_lo)
  );

  // acceptance: high never blocked by low, nothing pre-empts its own level
  always_comb
  begin
    take_hi  = hit_hi && !in_service_r[1];
    take     = insn_boundary && (state_r == TLIP_ST_IDLE) && !reti_done &&
               (take_hi || (hit_lo && in_service_r == 2'b00));
    take_idx = take_hi ? idx_hi : idx_lo;
  end

  // register writes, bit 7 of the priority registers kept
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      enable_reg_r                    <= `TLIP_RST_ENABLE;
      priority_select_reg_r           <= `TLIP_RST_PRIO;
      secondary_enable_priority_reg_r <= `TLIP_RST_SEC;
    end
    else if (ce)
    begin
      if ((sfr_wr || sfr_bit_wr) && sfr_addr == `TLIP_ADDR_ENABLE)
        enable_reg_r <= wr_merge(enable_reg_r, `TLIP_WMASK_ENABLE, sfr_wr,
                                 sfr_wdata, sfr_bit_sel, sfr_bit_val);
      else if ((sfr_wr || sfr_bit_wr) && sfr_addr == `TLIP_ADDR_PRIO)
        priority_select_reg_r <= wr_merge(priority_select_reg_r, `TLIP_WMASK_PRIO,
                                          sfr_wr, sfr_wdata, sfr_bit_sel,
                                          sfr_bit_val);
      else if (sfr_wr && sfr_addr == `TLIP_ADDR_SEC)
        secondary_enable_priority_reg_r <= (sfr_wdata & `TLIP_WMASK_SEC) |
          (secondary_enable_priority_reg_r & ~`TLIP_WMASK_SEC);
    end
  end

  // read port, registered
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sfr_rdata <= 8'h00;
      sfr_hit   <= 1'b0;
    end
    else if (ce)
    begin
      if (sfr_rd && sfr_addr == `TLIP_ADDR_ENABLE)
      begin
        sfr_rdata <= enable_reg_r;
        sfr_hit   <= 1'b1;
      end
      else if (sfr_rd && sfr_addr == `TLIP_ADDR_PRIO)
      begin
        sfr_rdata <= priority_select_reg_r;
        sfr_hit   <= 1'b1;
      end
      else if (sfr_rd && sfr_addr == `TLIP_ADDR_SEC)
      begin
        sfr_rdata <= secondary_enable_priority_reg_r;
        sfr_hit   <= 1'b1;
      end
      else
      begin
        sfr_rdata <= 8'h00;
        sfr_hit   <= 1'b0;
      end
    end
  end

  // vectoring sequence: push cycle then jump cycle
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_r     <= TLIP_ST_IDLE;
      pend_idx_r  <= 4'h0;
      pend_hi_r   <= 1'b0;
      push_pc     <= 1'b0;
      load_pc     <= 1'b0;
      vector_addr <= 16'h0000;
      ack_src     <= 4'h0;
    end
    else if (ce)
    begin
      push_pc <= 1'b0;
      load_pc <= 1'b0;
      case (state_r)
        TLIP_ST_IDLE:
        begin
          if (take)
          begin
            pend_idx_r <= take_idx;
            pend_hi_r  <= take_hi;
            push_pc    <= 1'b1;
            state_r    <= TLIP_ST_PUSH;
          end
        end
        TLIP_ST_PUSH:
        begin
          load_pc     <= 1'b1;
          vector_addr <= vec_of(pend_idx_r);
          ack_src     <= pend_idx_r;
          state_r     <= TLIP_ST_JUMP;
        end
        default:
          state_r <= TLIP_ST_IDLE;
      endcase
    end
  end

  // in-service markers; return clears the highest active level
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      in_service_r <= 2'b00;
    else if (ce)
    begin
      if (state_r == TLIP_ST_PUSH)
      begin
        if (pend_hi_r)
          in_service_r[1] <= 1'b1;
        else
          in_service_r[0] <= 1'b1;
      end
      else if (reti_done)
      begin
        if (in_service_r[1])
          in_service_r[1] <= 1'b0;
        else
          in_service_r[0] <= 1'b0;
      end
    end
  end

  // marker mirror for the core
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      in_service <= 2'b00;
    else if (ce)
      in_service <= in_service_r;
  end
endmodule : tlip_ctrl

// File: verilog/tlip_params.svh
`ifndef TLIP_PARAMS_SVH
`define TLIP_PARAMS_SVH
// special-function addresses
`define TLIP_ADDR_ENABLE       8'hA8
`define TLIP_ADDR_SEC          8'hA9
`define TLIP_ADDR_PRIO         8'hB8
// reset values
`define TLIP_RST_ENABLE        8'h00
`define TLIP_RST_SEC           8'hA0
`define TLIP_RST_PRIO          8'h00
// field positions
`define TLIP_BIT_GLOBAL        7
`define TLIP_BIT_SEC_RSVD      3
// write masks: bit 7 unimplemented in the two priority registers
`define TLIP_WMASK_SEC         8'h7F
`define TLIP_WMASK_PRIO        8'h7F
`define TLIP_WMASK_ENABLE      8'hFF
// vectors
`define TLIP_VEC_EXT0          16'h0003
`define TLIP_VEC_TIMER0        16'h000B
`define TLIP_VEC_EXT1          16'h0013
`define TLIP_VEC_TIMER1        16'h001B
`define TLIP_VEC_UART          16'h0023
`define TLIP_VEC_TIMER2        16'h002B
`define TLIP_VEC_ADC           16'h0033
`define TLIP_VEC_SERIAL        16'h003B
`define TLIP_VEC_SUPPLY        16'h0043
`define TLIP_VEC_INTERVAL      16'h0053
`define TLIP_VEC_WATCHDOG      16'h005B
// source count
`define TLIP_NSRC              11
`endif

// File: verilog/tlip_pkg.sv
package tlip_pkg;
  // sources listed in polling order, index 0 polled first
  typedef enum logic [3:0] {
    TLIP_SRC_SUPPLY,
    TLIP_SRC_WATCHDOG,
    TLIP_SRC_EXT0,
    TLIP_SRC_ADC,
    TLIP_SRC_TIMER0,
    TLIP_SRC_EXT1,
    TLIP_SRC_TIMER1,
    TLIP_SRC_SERIAL,
    TLIP_SRC_UART,
    TLIP_SRC_TIMER2,
    TLIP_SRC_INTERVAL
  } tlip_src_t;
  typedef enum logic [1:0] {
    TLIP_ST_IDLE,
    TLIP_ST_PUSH,
    TLIP_ST_JUMP
  } tlip_state_t;
endpackage : tlip_pkg

// File: verilog/tlip_poll.sv
`timescale 1ns/1ps
`include "tlip_params.svh"
// fixed-order poll of one priority level
module tlip_poll
  import tlip_pkg::*;
#(
  parameter int NSRC = `TLIP_NSRC
)(
  input  wire logic [NSRC-1:0] req,
  output logic                 hit,
  output logic [3:0]           idx
);
  // refuse a source count that the 4-bit index cannot name
  if (NSRC < 1 || NSRC > 16)
  begin : g_bad_nsrc
    $error("tlip_poll: NSRC out of range");
  end
  // lowest index wins
  always_comb
  begin
    hit = 1'b0;
    idx = 4'h0;
    for (int i = NSRC - 1; i >= 0; i--)
    begin
      if (req[i])
      begin
        hit = 1'b1;
        idx = 4'(i);
      end
    end
  end
endmodule : tlip_poll

// File: verification/tlip_ctrl_chk.sv
`timescale 1ns/1ps
// port-level checks of the interrupt controller
module tlip_ctrl_chk (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        ce,
  input wire logic [7:0]  sfr_addr,
  input wire logic        sfr_rd,
  input wire logic [7:0]  sfr_rdata,
  input wire logic        sfr_hit,
  input wire logic        reti_done,
  input wire logic        push_pc,
  input wire logic        load_pc,
  input wire logic [15:0] vector_addr,
  input wire logic [3:0]  ack_src,
  input wire logic [1:0]  in_service
);
  // vector of each source, in polling order
  localparam logic [15:0] VT [11] = '{16'h0043, 16'h005B, 16'h0003, 16'h0033, 16'h000B,
    16'h0013, 16'h001B, 16'h003B, 16'h0023, 16'h002B, 16'h0053};
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // vectoring sequence
  chk_push_then_load: assert property (push_pc |=> load_pc)
    else $error("load did not follow push");
  chk_load_one_cycle: assert property (load_pc |=> !load_pc && !push_pc)
    else $error("load pulse too long");
  chk_vec_low_table: assert property (load_pc && ack_src inside {4'h2, 4'h4, 4'h5, 4'h6, 4'h8}
    |-> vector_addr == VT[ack_src])
    else $error("wrong vector for low table source");
  chk_vec_high_table: assert property (load_pc && ack_src inside {4'h0, 4'h1, 4'h3, 4'h7, 4'h9,
    4'hA} |-> vector_addr == VT[ack_src])
    else $error("wrong vector for high table source");
  // nesting by level
  chk_high_blocks_all: assert property (in_service[1] |-> !push_pc)
    else $error("take while high level in service");
  chk_reti_clears_hi: assert property (reti_done && in_service == 2'b11
    |=> ##1 in_service == 2'b01)
    else $error("return did not drop the high marker");
  // register reads
  chk_mapped_hit: assert property (ce && sfr_rd && sfr_addr inside {8'hA8, 8'hA9, 8'hB8}
    |=> sfr_hit)
    else $error("mapped read without hit");
  chk_unmapped_zero: assert property (ce && sfr_rd && !(sfr_addr inside {8'hA8, 8'hA9, 8'hB8})
    |=> !sfr_hit && sfr_rdata == 8'h00)
    else $error("unmapped read answered");
  chk_prio_bit_seven: assert property (ce && sfr_rd && sfr_addr == 8'hB8 |=> !sfr_rdata[7])
    else $error("priority bit 7 moved");
  chk_sec_bit_seven: assert property (ce && sfr_rd && sfr_addr == 8'hA9 |=> sfr_rdata[7])
    else $error("secondary bit 7 moved");
  cov_preempt: cover property (in_service == 2'b11);
  cov_take_in_low: cover property (push_pc && in_service == 2'b01);
  cov_return: cover property (reti_done);
endmodule : tlip_ctrl_chk

bind tlip_ctrl tlip_ctrl_chk i_chk (.*);

// File: verification/tlip_core_model.sv
`timescale 1ns/1ps
// core side: offers boundaries, returns on request, counts nesting
module tlip_core_model (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       stall,
  input  wire logic       reti_req,
  input  wire logic       push_pc,
  output logic            insn_boundary,
  output logic            reti_done,
  output logic [3:0]      depth
);
  // a stalled core sits inside a long instruction
  assign insn_boundary = !stall;
  // return pulse only with something on the stack
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      reti_done <= 1'b0;
      depth     <= 4'h0;
    end
    else
    begin
      reti_done <= reti_req && depth != 4'h0;
      depth     <= depth + 4'(push_pc) - 4'(reti_done);
    end
endmodule : tlip_core_model

// File: verification/test_two_level_interrupt_priority.sv
`timescale 1ns/1ps
module test_two_level_interrupt_priority;
  logic        clk, rst, ce, sfr_wr, sfr_bit_wr, sfr_bit_val, sfr_rd, sfr_hit;
  logic        insn_boundary, reti_done, push_pc, load_pc, stall, reti_req;
  logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata;
  logic [2:0]  sfr_bit_sel;
  logic [15:0] vector_addr;
  logic [3:0]  ack_src, depth;
  logic [1:0]  in_service;
  logic [14:0] f;
  int          error_cnt, compares;
  // vector per polling index, polling index per flag bit
  localparam logic [15:0] VT [11] = '{16'h0043, 16'h005B, 16'h0003, 16'h0033, 16'h000B,
    16'h0013, 16'h001B, 16'h003B, 16'h0023, 16'h002B, 16'h0053};
  localparam int FI [15] = '{0, 1, 2, 5, 3, 3, 4, 6, 9, 9, 7, 7, 8, 8, 10};
  localparam int PO [11] = '{1, 0, 2, 3, 4, 5, 6, 7, 8, 9, 10};

  tlip_ctrl i_dut (.*, .supply_monitor_request(f[0]), .watchdog_request(f[1]),
    .ext0_request(f[2]), .ext1_request(f[3]), .adc_primary_done(f[4]),
    .adc_auxiliary_done(f[5]), .timer0_overflow(f[6]), .timer1_overflow(f[7]),
    .timer2_overflow(f[8]), .timer2_external_flag(f[9]), .spi_request(f[10]),
    .twowire_request(f[11]), .uart_receive_flag(f[12]), .uart_send_flag(f[13]),
    .interval_counter_request(f[14]));
  tlip_core_model i_core (.clk(clk), .rst(rst), .stall(stall), .reti_req(reti_req),
    .push_pc(push_pc), .insn_boundary(insn_boundary), .reti_done(reti_done), .depth(depth));

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // one access: k=0 read, 1 byte write, 2 bit write (sel d[2:0], value d[3])
  task automatic acc(input int k, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sfr_addr <= a;
    sfr_wdata <= d;
    {sfr_bit_val, sfr_bit_sel} <= d[3:0];
    {sfr_rd, sfr_wr, sfr_bit_wr} <= {k == 0, k == 1, k == 2};
    @(posedge clk);
    {sfr_rd, sfr_wr, sfr_bit_wr} <= 3'b000;
    #1;
  endtask : acc
  task automatic rdc(input logic [7:0] a, input logic [7:0] e, input logic h);
    acc(0, a, 8'h00);
    chk("rdata", 16'(e), 16'(sfr_rdata));
    chk("hit", 16'(h), 16'(sfr_hit));
  endtask : rdc
  task automatic raise(input logic [14:0] m);
    @(posedge clk);
    f <= f | m;
  endtask : raise
  task automatic quiet(input int n);
    repeat (n)
    begin
      @(posedge clk);
      #1;
      chk("push_pc", 16'h0000, 16'(push_pc));
    end
  endtask : quiet
  // wait for the vector load, bounded
  task automatic take(input int i);
    int n;
    n = 0;
    do
    begin
      @(posedge clk);
      #1;
      n++;
    end
    while (load_pc !== 1'b1 && n < 30);
    chk("load_pc", 16'h0001, 16'(load_pc));
    chk("ack_src", 16'(i), 16'(ack_src));
    chk("vector", VT[i], vector_addr);
  endtask : take
  task automatic ret;
    @(posedge clk);
    reti_req <= 1'b1;
    @(posedge clk);
    reti_req <= 1'b0;
  endtask : ret
  // service routine: take, clear own flags, return
  task automatic svc(input int i);
    take(i);
    @(posedge clk);
    for (int b = 0; b < 15; b++)
      if (FI[b] == i)
        f[b] <= 1'b0;
    ret();
  endtask : svc
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : tally_and_finish

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // a hang: the tests need a few hundred cycles
  initial
  begin
    #200000;
    error_cnt++;
    tally_and_finish();
  end
  initial
  begin
    {rst, ce, sfr_wr, sfr_bit_wr, sfr_rd, stall, reti_req} = 7'b1100000;
    {sfr_addr, sfr_wdata, sfr_bit_sel, sfr_bit_val, f} = '0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rdc(8'hA8, 8'h00, 1'b1);
    rdc(8'hA9, 8'hA0, 1'b1);
    rdc(8'hB8, 8'h00, 1'b1);
    rdc(8'h80, 8'h00, 1'b0);
    acc(1, 8'hB8, 8'hFF);
    rdc(8'hB8, 8'h7F, 1'b1);
    acc(2, 8'hB8, 8'h07);
    rdc(8'hB8, 8'h7F, 1'b1);
    acc(1, 8'hB8, 8'h00);
    acc(2, 8'hB8, 8'h08);
    rdc(8'hB8, 8'h01, 1'b1);
    acc(1, 8'hB8, 8'h00);
    ce <= 1'b0;
    acc(1, 8'hB8, 8'h55);
    ce <= 1'b1;
    rdc(8'hB8, 8'h00, 1'b1);
    acc(1, 8'hA9, 8'h77);
    rdc(8'hA9, 8'hF7, 1'b1);
    acc(2, 8'hA9, 8'h00);
    rdc(8'hA9, 8'hF7, 1'b1);
    $display("registers done");
    acc(1, 8'hA8, 8'hFF);
    acc(1, 8'hA9, 8'h07);
    for (int b = 0; b < 15; b++)
    begin
      raise(15'(1) << b);
      svc(FI[b]);
    end
    $display("vectors done");
    raise(15'h7FFF);
    foreach (PO[k])
      svc(PO[k]);
    $display("polling done");
    acc(1, 8'hA9, 8'h47);
    raise(15'h0040);
    take(4);
    raise(15'h4008);
    take(10);
    @(posedge clk);
    f[14] <= 1'b0;
    #1;
    chk("in_service", 16'h0003, 16'(in_service));
    ret();
    quiet(8);
    chk("in_service", 16'h0001, 16'(in_service));
    f[6] <= 1'b0;
    ret();
    svc(5);
    $display("nesting done");
    acc(1, 8'hA8, 8'h7F);
    acc(1, 8'hA9, 8'h40);
    raise(15'h4040);
    quiet(8);
    acc(1, 8'hA8, 8'hFD);
    quiet(8);
    stall <= 1'b1;
    acc(1, 8'hA8, 8'hFF);
    quiet(6);
    stall <= 1'b0;
    f[14] <= 1'b0;
    svc(4);
    repeat (2) @(posedge clk);
    #1;
    chk("depth", 16'h0000, 16'(depth));
    $display("gating done");
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    rdc(8'hA8, 8'h00, 1'b1);
    rdc(8'hA9, 8'hA0, 1'b1);
    $display("reset done");
    tally_and_finish();
  end
endmodule : test_two_level_interrupt_priority
